// ### verilog/hbc_top.sv
// Half-bridge input control: pin/register combine, state table, dead time, AXI4-Lite regs
`timescale 1ns/1ps

// Contract
// RULE1 - Sleep pin low forces sleep state and high-impedance output, ignoring other inputs.
// RULE2 - Awake: disable high and input low is standby Hi-Z; disable low drives input.
// RULE3 - Active high with trip regulation enabled and level reached forces low fixed time.
// RULE4 - Dead time inserted at every switch-over from gate feedback; never both on. The code ends it after DEAD_CYCLES even if feedback still shows on.
// RULE5 - Undriven sleep input reads low, undriven disable input reads high.
// RULE6 - Undriven drive-input pin reads as logic zero.
// RULE7 - Register copies steer the bridge only after the unlock key is written.
// RULE8 - Combine select zero: effective signal is pin OR register bit.
// RULE9 - Combine select one: effective signal is pin AND register bit.
// RULE10 - Same state table applies using combined disable and input signals.
// RULE11 - Sleep is controlled only by its pin; no register copy exists.
// RULE12 - Pin-only disable: controller sets select one and register disable bit one.
// RULE13 - Register-only input: controller grounds input pin and sets select zero.
// RULE14 - Register copies are written over the serial register port; the code writes them over the AXI4-Lite write channel instead.
// RULE15 - Standby with input high: diagnostics decide output; disabled means Hi-Z.
module hbc_top (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              clk_en,
	input  wire hbc_pkg::hbc_pins_t pins,
	input  wire logic              diag_drive,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output hbc_pkg::hbc_gate_t     gate,
	output hbc_pkg::hbc_mode_t     mode
);

	// ---------------------------------------------------------------
	// State record
	// ---------------------------------------------------------------
	typedef struct packed {
		hbc_pkg::hbc_pins_t  sync1;
		hbc_pkg::hbc_pins_t  sync2;
		logic                unlocked;
		logic [1:0]          reg_in;
		logic [1:0]          combine;
		logic [1:0]          trip_cfg;
		logic                trip_seen;
		logic                aw_held;
		logic [7:0]          aw_addr;
		logic                w_held;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		hbc_pkg::hbc_drive_t drive;
		logic [hbc_pkg::DEAD_W-1:0] dead_cnt;
		logic [hbc_pkg::TOFF_W-1:0] toff_cnt;
		logic                toff_act;
		logic                last_dis;
		logic                last_in;
		hbc_pkg::hbc_mode_t  mode;
		hbc_pkg::hbc_gate_t  gate;
	} hbc_state_t;

	hbc_state_t st;
	hbc_state_t next_st;

	// Combinational helpers
	logic                eff_dis;
	logic                eff_in;
	logic                pin_dis;
	logic                pin_in;
	logic                sleep_ok;
	hbc_pkg::hbc_mode_t  want_mode;
	hbc_pkg::hbc_drive_t want_drive;
	logic                trip_hit;
	logic                inputs_moved;
	logic                wr_fire;
	logic [31:0]         merged;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Two-stage synchronisers for all pin inputs
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;

		// Pull levels are analog; synchronised pins already carry them
		sleep_ok = st.sync2.sleep_bar_pin;       // RULE5 RULE11
		pin_dis  = st.sync2.output_disable_pin;  // RULE5
		pin_in   = st.sync2.drive_input_pin;     // RULE6

		// Register copies count only once unlocked; neutral values otherwise
		if (st.unlocked) begin // RULE7
			eff_dis = st.combine[hbc_pkg::BIT_SEL_DISABLE]
				? (pin_dis & st.reg_in[hbc_pkg::BIT_REG_DISABLE])  // RULE9
				: (pin_dis | st.reg_in[hbc_pkg::BIT_REG_DISABLE]); // RULE8
			eff_in = st.combine[hbc_pkg::BIT_SEL_INPUT]
				? (pin_in & st.reg_in[hbc_pkg::BIT_REG_INPUT])     // RULE9
				: (pin_in | st.reg_in[hbc_pkg::BIT_REG_INPUT]);    // RULE8
		end else begin
			eff_dis = pin_dis;
			eff_in  = pin_in;
		end

		// State table on combined signals
		if (!sleep_ok) begin // RULE1
			want_mode  = hbc_pkg::HBC_SLEEP;
			want_drive = hbc_pkg::HBC_OUT_HIZ;
		end else if (eff_dis) begin // RULE2 RULE10
			want_mode  = hbc_pkg::HBC_STANDBY;
			want_drive = (eff_in && diag_drive) ? hbc_pkg::HBC_OUT_HIGH
				: hbc_pkg::HBC_OUT_HIZ; // RULE15
		end else begin // RULE2 RULE10
			want_mode  = hbc_pkg::HBC_ACTIVE;
			want_drive = eff_in ? hbc_pkg::HBC_OUT_HIGH : hbc_pkg::HBC_OUT_LOW;
		end

		// Off-time: user input change cancels the remainder
		inputs_moved = (eff_dis != st.last_dis) || (eff_in != st.last_in);
		next_st.last_dis = eff_dis;
		next_st.last_in  = eff_in;
		trip_hit = st.trip_cfg[hbc_pkg::BIT_TRIP_EN] && st.sync2.trip_level
			&& (st.drive == hbc_pkg::HBC_OUT_HIGH);
		next_st.trip_seen = st.trip_seen | trip_hit;
		if (inputs_moved || want_mode != hbc_pkg::HBC_ACTIVE) begin
			next_st.toff_act = 1'b0;
			next_st.toff_cnt = '0;
		end else if (trip_hit && !st.toff_act) begin // RULE3
			next_st.toff_act = 1'b1;
			next_st.toff_cnt = hbc_pkg::TOFF_W'(hbc_pkg::TOFF_CYCLES - 1);
		end else if (st.toff_act) begin
			if (st.toff_cnt == '0) begin
				next_st.toff_act = 1'b0;
			end else begin
				next_st.toff_cnt = st.toff_cnt - 1'b1;
			end
		end
		if (next_st.toff_act && want_drive == hbc_pkg::HBC_OUT_HIGH) begin
			want_drive = hbc_pkg::HBC_OUT_LOW; // RULE3
		end

		// Dead time: pass through an all-off phase until both gates report off or DEAD_CYCLES run out
		case (st.drive)
			hbc_pkg::HBC_OUT_DEAD: begin
				if ((!st.sync2.high_gate_fb && !st.sync2.low_gate_fb)
						|| st.dead_cnt == '0) begin // RULE4
					// Fresh choice: a target kept from before could drive in sleep
					next_st.drive = want_drive;
				end else begin
					next_st.dead_cnt = st.dead_cnt - 1'b1;
				end
			end
			hbc_pkg::HBC_OUT_HIGH, hbc_pkg::HBC_OUT_LOW: begin
				if (want_drive != st.drive) begin // RULE4
					next_st.drive    = hbc_pkg::HBC_OUT_DEAD;
					next_st.dead_cnt = hbc_pkg::DEAD_W'(hbc_pkg::DEAD_CYCLES - 1);
				end
			end
			default: begin
				next_st.drive = want_drive;
			end
		endcase
		next_st.gate.high_on = (next_st.drive == hbc_pkg::HBC_OUT_HIGH); // RULE4
		next_st.gate.low_on  = (next_st.drive == hbc_pkg::HBC_OUT_LOW);
		next_st.mode         = want_mode;

		// AXI4-Lite write channel: address and data in either order
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		wr_fire = st.aw_held && st.w_held && !st.bvalid;
		merged  = st.w_data;
		if (wr_fire) begin // RULE14
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = hbc_pkg::AXI_OKAY;
			if (st.w_strb[0]) begin
				case (st.aw_addr)
					hbc_pkg::OFF_COMMAND: begin
						if (merged[hbc_pkg::LOCK_LSB +: hbc_pkg::LOCK_W]
								== hbc_pkg::KEY_UNLOCK) begin
							next_st.unlocked = 1'b1; // RULE7
						end else if (merged[hbc_pkg::LOCK_LSB +: hbc_pkg::LOCK_W]
								== hbc_pkg::KEY_LOCK) begin
							next_st.unlocked = 1'b0;
						end
					end
					hbc_pkg::OFF_REG_IN:  next_st.reg_in   = merged[1:0];
					hbc_pkg::OFF_COMBINE: next_st.combine  = merged[1:0];
					hbc_pkg::OFF_TRIP: begin
						next_st.trip_cfg = merged[1:0];
						// Write one to bit 8 clears the sticky trip flag; new hit wins
						if (st.w_strb[1] && merged[8]) begin
							next_st.trip_seen = trip_hit;
						end
					end
					hbc_pkg::OFF_STATUS: next_st.bresp = hbc_pkg::AXI_OKAY;
					default: next_st.bresp = hbc_pkg::AXI_SLVERR;
				endcase
			end
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// AXI4-Lite read channel
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = hbc_pkg::AXI_OKAY;
			next_st.rdata  = 32'h0;
			case (s_axi_araddr)
				hbc_pkg::OFF_COMMAND: next_st.rdata = {31'h0, st.unlocked};
				hbc_pkg::OFF_REG_IN:  next_st.rdata = {30'h0, st.reg_in};
				hbc_pkg::OFF_COMBINE: next_st.rdata = {30'h0, st.combine};
				hbc_pkg::OFF_TRIP:
					next_st.rdata = {23'h0, st.trip_seen, 6'h0, st.trip_cfg};
				hbc_pkg::OFF_STATUS:
					next_st.rdata = {24'h0, st.toff_act, eff_in, eff_dis,
						sleep_ok, st.mode, st.gate.high_on, st.gate.low_on};
				default: next_st.rresp = hbc_pkg::AXI_SLVERR;
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Reset puts the bridge safe: everything off, locked, sleep reported
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= '0;
			st.sync1.output_disable_pin <= 1'b1;
			st.sync2.output_disable_pin <= 1'b1;
			st.reg_in   <= hbc_pkg::RST_REG_IN;
			st.combine  <= hbc_pkg::RST_COMBINE;
			st.trip_cfg <= hbc_pkg::RST_TRIP;
			st.drive    <= hbc_pkg::HBC_OUT_HIZ;
			st.mode     <= hbc_pkg::HBC_SLEEP;
			st.last_dis <= 1'b1;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from the state record
	// ---------------------------------------------------------------
	assign s_axi_awready = !st.aw_held;
	assign s_axi_wready  = !st.w_held;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign gate          = st.gate;
	assign mode          = st.mode;

endmodule // hbc_top

// ### verilog/hbc_pkg.sv
// Package for the half-bridge input control block: register map, fields, timing
package hbc_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_COMMAND = 8'h00; // Unlock key field
	localparam logic [7:0] OFF_REG_IN  = 8'h04; // Register copies of disable and input
	localparam logic [7:0] OFF_COMBINE = 8'h08; // combine_select_config
	localparam logic [7:0] OFF_TRIP    = 8'h0C; // Trip regulation enable
	localparam logic [7:0] OFF_STATUS  = 8'h10; // Read-only block state

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int LOCK_LSB        = 0;
	localparam int LOCK_W          = 3;
	localparam int BIT_REG_DISABLE = 0; // reg_output_disable
	localparam int BIT_REG_INPUT   = 1; // Register input copy
	localparam int BIT_SEL_DISABLE = 0; // disable_combine_select
	localparam int BIT_SEL_INPUT   = 1; // Input combine select
	localparam int BIT_TRIP_EN     = 0;
	localparam int BIT_DIAG_EN     = 1;

	// ---------------------------------------------------------------
	// Keys and reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] KEY_UNLOCK     = 3'h5;
	localparam logic [2:0] KEY_LOCK       = 3'h2;
	localparam logic [1:0] RST_REG_IN     = 2'h1; // Disable copy set, input clear
	localparam logic [1:0] RST_COMBINE    = 2'h0;
	localparam logic [1:0] RST_TRIP       = 2'h0;
	localparam logic [1:0] AXI_OKAY       = 2'h0;
	localparam logic [1:0] AXI_SLVERR     = 2'h2;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ       = 125;
	localparam int TOFF_US       = 30;
	localparam int TOFF_CYCLES   = TOFF_US * CLK_MHZ; // 3750 cycles, fixed off time
	localparam int DEAD_CYCLES   = 4;                 // Ceiling on gate feedback wait
	localparam int TOFF_W        = 12;
	localparam int DEAD_W        = 3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		HBC_SLEEP,
		HBC_STANDBY,
		HBC_ACTIVE
	} hbc_mode_t;

	typedef enum logic [1:0] {
		HBC_OUT_HIZ,
		HBC_OUT_DEAD,
		HBC_OUT_LOW,
		HBC_OUT_HIGH
	} hbc_drive_t;

	typedef struct packed {
		logic high_on;
		logic low_on;
	} hbc_gate_t;

	typedef struct packed {
		logic sleep_bar_pin;
		logic output_disable_pin;
		logic drive_input_pin;
		logic trip_level;
		logic high_gate_fb;
		logic low_gate_fb;
	} hbc_pins_t;

endpackage

// ### tb/hbc_chk.sv
// Port checker for the half-bridge input control block
`timescale 1ns/1ps
module hbc_chk (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire hbc_pkg::hbc_pins_t pins,
	input wire logic               diag_drive,
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic [7:0]         s_axi_araddr,
	input wire logic               s_axi_rvalid,
	input wire logic [1:0]         s_axi_rresp,
	input wire hbc_pkg::hbc_gate_t gate,
	input wire hbc_pkg::hbc_mode_t mode
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] dz;
	// Count active cycles with both gates off; saturates so it never wraps
	always_ff @(posedge aclk) begin
		if (!aresetn || !(mode == hbc_pkg::HBC_ACTIVE && gate == 2'b00))
			dz <= 3'h0;
		else if (dz != 3'h7)
			dz <= dz + 3'h1;
	end
	a_never_both: assert property (!(gate.high_on && gate.low_on))
		else $error("both gates on");
	a_dead_high: assert property ($rose(gate.high_on) |-> !$past(gate.low_on))
		else $error("high gate without dead time");
	a_dead_low: assert property ($rose(gate.low_on) |-> !$past(gate.high_on))
		else $error("low gate without dead time");
	a_dead_bound: assert property (dz < 3'h6)
		else $error("dead time too long");
	a_sleep_pin: assert property ((!pins.sleep_bar_pin)[*4] |-> mode == hbc_pkg::HBC_SLEEP)
		else $error("sleep pin ignored");
	a_sleep_hiz: assert property (mode == hbc_pkg::HBC_SLEEP |-> gate == 2'b00)
		else $error("output driven in sleep");
	a_standby_hiz: assert property ((mode == hbc_pkg::HBC_STANDBY && !diag_drive)[*3]
		|-> gate == 2'b00)
		else $error("output driven in standby");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_error: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
		|=> s_axi_rvalid && s_axi_rresp == hbc_pkg::AXI_SLVERR)
		else $error("unmapped read not refused");
	c_high: cover property (mode == hbc_pkg::HBC_ACTIVE && gate.high_on);
	c_low: cover property (mode == hbc_pkg::HBC_ACTIVE && gate.low_on);
	c_standby: cover property (mode == hbc_pkg::HBC_STANDBY);
endmodule // hbc_chk

bind hbc_top hbc_chk chk_i (.aclk, .aresetn, .pins, .diag_drive, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rresp, .gate, .mode);

// ### tb/hbc_ctrl_model.sv
// Controller pin model with a lagging power-stage gate feedback
`timescale 1ns/1ps
module hbc_ctrl_model (
	input  wire logic               aclk,
	input  wire logic [2:0]         want,   // Sleep_bar, disable, input levels
	input  wire logic [2:0]         driven, // Per-pin drive flags
	input  wire logic               trip,
	input  wire hbc_pkg::hbc_gate_t gate,
	output hbc_pkg::hbc_pins_t      pins
);
	logic [1:0] fb1 = 2'b00;
	logic [1:0] fb2 = 2'b00;
	// Gate charge decays over two cycles, so the dead time really waits
	always_ff @(posedge aclk) begin
		fb1 <= gate;
		fb2 <= fb1 | gate;
	end
	// Undriven pins settle to their bias: sleep low, disable high, input low
	assign pins.sleep_bar_pin      = driven[2] ? want[2] : 1'b0;
	assign pins.output_disable_pin = driven[1] ? want[1] : 1'b1;
	assign pins.drive_input_pin    = driven[0] ? want[0] : 1'b0;
	assign pins.trip_level         = trip;
	assign pins.high_gate_fb       = fb2[1] | gate.high_on;
	assign pins.low_gate_fb        = fb2[0] | gate.low_on;
endmodule // hbc_ctrl_model

// ### tb/half_bridge_input_control_test.sv
// Self-checking bench for the half-bridge input control block
`timescale 1ns/1ps
module half_bridge_input_control_test;
	logic               aclk, aresetn, diag, trip, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
	logic               ce;
	logic [2:0]         want, drv, p;
	logic [7:0]         awa, ara;
	logic [31:0]        wd, rd_d;
	logic [1:0]         bresp, rresp, sel, rb;
	logic [3:0]         v;
	hbc_pkg::hbc_pins_t pins;
	hbc_pkg::hbc_gate_t gate;
	hbc_pkg::hbc_mode_t mode;
	int                 mismatches, compares, cyc;

	hbc_ctrl_model ctl (.aclk(aclk), .want(want), .driven(drv), .trip(trip), .gate(gate),
		.pins(pins));
	hbc_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .pins(pins), .diag_drive(diag),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .gate(gate), .mode(mode));

	// Clock and watchdog; the ceiling leaves ample room over the trip wait
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rr <= 1'b0;
		chk("rresp", er, rresp);
		chk("rdata", ed, rd_d);
	endtask
	// Pins change, then wait out sync, state and dead time
	task automatic drive(input logic [2:0] w, input logic [2:0] d, input logic g);
		@(posedge aclk);
		want <= w;
		drv <= d;
		diag <= g;
		repeat (12) @(posedge aclk);
	endtask
	function automatic logic [3:0] model(input logic s, input logic d, input logic i,
		input logic g);
		if (!s) return {hbc_pkg::HBC_SLEEP, 2'b00};
		if (d) return {hbc_pkg::HBC_STANDBY, i & g, 1'b0};
		return {hbc_pkg::HBC_ACTIVE, i, !i};
	endfunction
	function automatic logic eff(input logic pin, input logic r, input logic s);
		return s ? (pin & r) : (pin | r);
	endfunction

	// Main sequence
	initial begin
		{aresetn, diag, trip, awv, wv, br, arv, rr, want, drv, awa, ara, wd} = '0;
		mismatches = 0;
		compares = 0;
		cyc = 0;
		ce = 1'b1;
		void'($urandom(54066));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(hbc_pkg::OFF_REG_IN, hbc_pkg::AXI_OKAY, {30'h0, hbc_pkg::RST_REG_IN});
		rd(hbc_pkg::OFF_COMBINE, hbc_pkg::AXI_OKAY, {30'h0, hbc_pkg::RST_COMBINE});
		rd(hbc_pkg::OFF_COMMAND, hbc_pkg::AXI_OKAY, 32'h0);
		rd(8'h14, hbc_pkg::AXI_SLVERR, 32'h0);
		wr(8'h18, 32'h0, hbc_pkg::AXI_SLVERR);
		chk("idle", model(1'b0, 1'b1, 1'b0, 1'b0), {mode, gate});
		$display("test registers and idle done");
		for (int k = 0; k < 36; k++) begin
			v = (k < 16) ? k[3:0] : 4'($urandom);
			drive(v[2:0], 3'h7, v[3]);
			chk("pins", model(v[2], v[1], v[0], v[3]), {mode, gate});
		end
		$display("test pin table done");
		wr(hbc_pkg::OFF_REG_IN, 32'h2, hbc_pkg::AXI_OKAY);
		wr(hbc_pkg::OFF_COMBINE, 32'h3, hbc_pkg::AXI_OKAY);
		drive(3'b110, 3'h7, 1'b0);
		chk("locked", model(1'b1, 1'b1, 1'b0, 1'b0), {mode, gate});
		wr(hbc_pkg::OFF_COMMAND, {29'h0, hbc_pkg::KEY_UNLOCK}, hbc_pkg::AXI_OKAY);
		rd(hbc_pkg::OFF_COMMAND, hbc_pkg::AXI_OKAY, 32'h1);
		for (int k = 0; k < 40; k++) begin
			v = (k < 16) ? k[3:0] : 4'($urandom);
			sel = v[1:0];
			rb = v[3:2];
			wr(hbc_pkg::OFF_COMBINE, {30'h0, sel}, hbc_pkg::AXI_OKAY);
			wr(hbc_pkg::OFF_REG_IN, {30'h0, rb}, hbc_pkg::AXI_OKAY);
			p = 3'($urandom);
			drive(p, 3'h7, 1'b0);
			chk("mix", model(p[2], eff(p[1], rb[0], sel[0]), eff(p[0], rb[1], sel[1]), 1'b0),
				{mode, gate});
		end
		wr(hbc_pkg::OFF_COMBINE, 32'h1, hbc_pkg::AXI_OKAY);
		wr(hbc_pkg::OFF_REG_IN, 32'h3, hbc_pkg::AXI_OKAY);
		drive(3'b100, 3'b110, 1'b0);
		chk("reg input", model(1'b1, 1'b0, 1'b1, 1'b0), {mode, gate});
		$display("test unlocked combine done");
		wr(hbc_pkg::OFF_COMMAND, {29'h0, hbc_pkg::KEY_LOCK}, hbc_pkg::AXI_OKAY);
		drive(3'b100, 3'h7, 1'b0);
		chk("relocked", model(1'b1, 1'b0, 1'b0, 1'b0), {mode, gate});
		// Clock enable low: a pin change to standby must not be seen
		@(posedge aclk);
		ce <= 1'b0;
		drive(3'b110, 3'h7, 1'b0);
		chk("frozen", model(1'b1, 1'b0, 1'b0, 1'b0), {mode, gate});
		ce <= 1'b1;
		repeat (12) @(posedge aclk);
		chk("thawed", model(1'b1, 1'b1, 1'b0, 1'b0), {mode, gate});
		$display("test relock and freeze done");
		wr(hbc_pkg::OFF_TRIP, 32'h1, hbc_pkg::AXI_OKAY);
		drive(3'b101, 3'h7, 1'b0);
		trip <= 1'b1;
		repeat (20) @(posedge aclk);
		chk("trip", {hbc_pkg::HBC_ACTIVE, 2'b01}, {mode, gate});
		trip <= 1'b0;
		repeat (hbc_pkg::TOFF_CYCLES - 70) @(posedge aclk);
		chk("off time", {hbc_pkg::HBC_ACTIVE, 2'b01}, {mode, gate});
		repeat (100) @(posedge aclk);
		chk("resume", {hbc_pkg::HBC_ACTIVE, 2'b10}, {mode, gate});
		// Sticky trip flag seen, then cleared by a write of one to bit 8
		rd(hbc_pkg::OFF_TRIP, hbc_pkg::AXI_OKAY, 32'h0000_0101);
		wr(hbc_pkg::OFF_TRIP, 32'h0000_0101, hbc_pkg::AXI_OKAY);
		rd(hbc_pkg::OFF_TRIP, hbc_pkg::AXI_OKAY, 32'h0000_0001);
		rd(hbc_pkg::OFF_STATUS, hbc_pkg::AXI_OKAY,
			{24'h0, 4'h5, hbc_pkg::HBC_ACTIVE, 2'b10});
		$display("test trip off time done");
		print_verdict();
	end
endmodule // half_bridge_input_control_test
